// File: verilog/sfm_ctrl_top.sv
// Flash mode control: continuous read, four-wire mode, software reset
// Contract
// [RULE_01] Mode field 10 keeps continuous read
// [RULE_02] Other mode field leaves continuous read
// [RULE_03] Only dual/quad I/O reads capture mode
// [RULE_04] Continuous read skips opcode decoding
// [RULE_05] Release opcode ends continuous and four-wire
// [RULE_06] Host sends release after power-on
// [RULE_07] Four-wire entry needs quad enable set
// [RULE_08] Entry ignored while quad enable clear
// [RULE_09] Mode switch keeps latch, suspend, wrap
// [RULE_10] Disable opcode or cleared enable exits
// [RULE_11] Disable opcode also ends continuous read
// [RULE_12] No-op only cancels armed reset
// [RULE_13] Arm then reset performs software reset
// [RULE_14] Other command disarms pending reset
// [RULE_15] Reset aborts running program or erase
// [RULE_16] Host waits after power-up before commands
// [RULE_17] Table word advertises reset and features
// [RULE_18] Table gives wrap opcode and lengths
// [RULE_19] Table word reports lock capabilities
// [RULE_20] Continuous state survives deselect
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
module sfm_ctrl_top
  import sfm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic flash_cs_n_i,
  input wire logic flash_sclk_i,
  input wire logic [3:0] flash_io_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cont_read_o,
  output logic qpi_mode_o,
  output logic soft_reset_o,
  output logic pe_abort_o
);

  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sfm_link_if lk ();

  sfm_link_rx u_rx (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .flash_cs_n_i(flash_cs_n_i),
    .flash_sclk_i(flash_sclk_i),
    .flash_io_i(flash_io_i),
    .lk(lk)
  );

  sfm_state_e state;
  logic rd_quad;
  logic [1:0] addr_cnt;
  logic reset_armed;
  logic [7:0] reset_count;
  logic quad_enable_bit;
  logic wel;
  logic suspend;
  logic [1:0] wrap_len;
  logic pe_busy;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic op_hit;
  logic addr_hit;
  logic mode_hit;
  logic rel_hit;
  logic [7:0] op;

  assign op = lk.byte_data;
  assign op_hit = lk.byte_valid && (state == SFM_ST_OPC);
  assign addr_hit = lk.byte_valid && (state == SFM_ST_ADDR);
  assign mode_hit = lk.byte_valid && (state == SFM_ST_MODE);
  // A first address byte of FF in continuous read is beyond the array, so it marks a release
  assign rel_hit = addr_hit && cont_read_o && (addr_cnt == 2'h0) && (op == SFM_OP_CONT_RELEASE);

  // Register read decode
  function automatic logic [31:0] read_word(logic [7:0] a, logic [31:0] ctrl, logic [31:0] stat);
    if (a == SFM_OFS_CTRL) begin
      read_word = ctrl;
    end else if (a == SFM_OFS_STATUS) begin
      read_word = stat;
    end else if (a == SFM_OFS_PTAB_64) begin
      read_word = SFM_PTAB_64; // [RULE_17] [RULE_18]
    end else if (a == SFM_OFS_PTAB_68) begin
      read_word = SFM_PTAB_68; // [RULE_19]
    end else begin
      read_word = 32'h0000_0000;
    end
  endfunction

  function automatic logic is_mapped(logic [7:0] a);
    is_mapped = (a == SFM_OFS_CTRL) || (a == SFM_OFS_STATUS) ||
                (a == SFM_OFS_PTAB_64) || (a == SFM_OFS_PTAB_68);
  endfunction

  // Bus width per phase; a read keeps its width through continuous reads
  always_comb begin
    case (state)
      SFM_ST_OPC: lk.width = qpi_mode_o ? SFM_W_X4 : SFM_W_X1;
      SFM_ST_ADDR, SFM_ST_MODE: lk.width = (rd_quad || qpi_mode_o) ? SFM_W_X4 : SFM_W_X2;
      default: lk.width = SFM_W_X1;
    endcase
  end

  // Transaction sequencer
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SFM_ST_IDLE;
      addr_cnt <= 2'h0;
      rd_quad <= 1'b0;
    end else if (soft_reset_o) begin
      state <= SFM_ST_IDLE; // [RULE_13]
    end else if (lk.frame_end) begin
      state <= SFM_ST_IDLE;
    end else if (lk.frame_start) begin
      // Opcode phase is skipped while continuous read holds
      state <= cont_read_o ? SFM_ST_ADDR : SFM_ST_OPC; // [RULE_04] [RULE_20]
      addr_cnt <= 2'h0;
    end else if (op_hit) begin
      if ((op == SFM_OP_DUAL_IO_READ && !qpi_mode_o) || op == SFM_OP_QUAD_IO_READ) begin
        state <= SFM_ST_ADDR; // [RULE_03]
        rd_quad <= (op == SFM_OP_QUAD_IO_READ);
      end else begin
        state <= SFM_ST_DATA;
      end
    end else if (addr_hit) begin
      addr_cnt <= addr_cnt + 2'h1;
      if (rel_hit) begin
        state <= SFM_ST_DATA;
      end else if (addr_cnt == SFM_ADDR_LAST) begin
        state <= SFM_ST_MODE;
      end
    end else if (mode_hit) begin
      state <= SFM_ST_DATA;
    end
  end

  // Continuous read flag, judged afresh from each mode byte
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cont_read_o <= 1'b0;
    end else if (soft_reset_o) begin
      cont_read_o <= 1'b0; // [RULE_13]
    end else if (op_hit && op == SFM_OP_CONT_RELEASE) begin
      cont_read_o <= 1'b0; // [RULE_05] [RULE_11]
    end else if (rel_hit) begin
      cont_read_o <= 1'b0; // [RULE_05]
    end else if (mode_hit) begin
      // Reserved mode bits are simply not looked at
      cont_read_o <= (op[SFM_MODE_FIELD_LSB +: 2] == SFM_MODE_CONTINUE); // [RULE_01] [RULE_02] [RULE_03]
    end
  end

  // Four-wire command mode
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qpi_mode_o <= 1'b0;
    end else if (soft_reset_o || !quad_enable_bit) begin
      qpi_mode_o <= 1'b0; // [RULE_10] [RULE_13]
    end else if ((op_hit && op == SFM_OP_CONT_RELEASE) || rel_hit) begin
      qpi_mode_o <= 1'b0; // [RULE_05] [RULE_10]
    end else if (op_hit && op == SFM_OP_QPI_ENTER) begin
      qpi_mode_o <= 1'b1; // [RULE_07] [RULE_08]
    end
  end

  // Reset arming; any complete opcode but the arm opcode, no-op included, disarms
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_armed <= 1'b0;
      soft_reset_o <= 1'b0;
      reset_count <= SFM_CNT_RST;
    end else begin
      soft_reset_o <= op_hit && reset_armed && (op == SFM_OP_RESET); // [RULE_13]
      if (soft_reset_o) begin
        reset_armed <= 1'b0;
        reset_count <= reset_count + 8'h01;
      end else if (op_hit) begin
        reset_armed <= (op == SFM_OP_RESET_ARM); // [RULE_12] [RULE_14]
      end
    end
  end

  // Abort of a running program or erase; data may be left damaged
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pe_abort_o <= 1'b0;
    end else begin
      pe_abort_o <= soft_reset_o && pe_busy; // [RULE_15]
    end
  end

  // Write channel: address and data taken in either order
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SFM_RESP_OKAY;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_q) ? SFM_RESP_OKAY : SFM_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control register; mode changes never touch these settings [RULE_09]
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quad_enable_bit <= 1'b0;
      wel <= 1'b0;
      suspend <= 1'b0;
      wrap_len <= SFM_WRAP_RST;
      pe_busy <= 1'b0;
    end else if (soft_reset_o) begin
      // Volatile settings back to power-on values; quad enable is kept
      wel <= 1'b0; // [RULE_13]
      suspend <= 1'b0;
      wrap_len <= SFM_WRAP_RST;
      pe_busy <= 1'b0; // [RULE_15]
    end else if (wr_fire && aw_q == SFM_OFS_CTRL) begin
      if (wstrb_q[0]) begin
        quad_enable_bit <= w_q[SFM_CTRL_QUAD_ENABLE];
        wel <= w_q[SFM_CTRL_WEL];
        suspend <= w_q[SFM_CTRL_SUSP];
        wrap_len <= w_q[SFM_CTRL_WRAP_LSB +: 2];
      end
      if (wstrb_q[1]) begin
        pe_busy <= w_q[SFM_CTRL_PE_BUSY];
      end
    end
  end

  // Read channel, answered one cycle after the address is taken
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SFM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? SFM_RESP_OKAY : SFM_RESP_SLVERR;
      s_axi_rdata <= read_word(s_axi_araddr,
        {23'h0, pe_busy, 2'h0, wrap_len, 1'b0, suspend, wel, quad_enable_bit},
        {16'h0, reset_count, 5'h0, reset_armed, qpi_mode_o, cont_read_o});
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks on the decoder
  cont_keep_a: assert property ( // [RULE_01]
    mode_hit && !soft_reset_o && op[5:4] == 2'b10 |=> cont_read_o)
    else $error("continuous read not held after mode 10");

  cont_leave_a: assert property ( // [RULE_02]
    mode_hit && op[5:4] != 2'b10 |=> !cont_read_o)
    else $error("continuous read kept after other mode field");

  cont_skip_op_a: assert property ( // [RULE_04]
    lk.frame_start && cont_read_o && !soft_reset_o && !lk.frame_end |=> state == SFM_ST_ADDR)
    else $error("opcode phase not skipped in continuous read");

  release_exit_a: assert property ( // [RULE_05]
    op_hit && op == SFM_OP_CONT_RELEASE |=> !cont_read_o && !qpi_mode_o)
    else $error("release opcode left a mode active");

  qpi_enter_a: assert property ( // [RULE_07]
    op_hit && op == SFM_OP_QPI_ENTER && quad_enable_bit && !soft_reset_o |=> qpi_mode_o)
    else $error("four-wire mode not entered");

  qpi_refuse_a: assert property ( // [RULE_08]
    op_hit && op == SFM_OP_QPI_ENTER && !quad_enable_bit && !qpi_mode_o |=> !qpi_mode_o [*2])
    else $error("four-wire mode entered without quad enable");

  mode_keeps_a: assert property ( // [RULE_09]
    qpi_mode_o != $past(qpi_mode_o) && !$past(soft_reset_o) && !$past(wr_fire)
      |-> $stable(wel) && $stable(suspend) && $stable(wrap_len))
    else $error("mode switch changed volatile settings");

  qe_drop_a: assert property ( // [RULE_10]
    !quad_enable_bit |=> !qpi_mode_o)
    else $error("four-wire mode held with quad enable clear");

  reset_seq_a: assert property ( // [RULE_13]
    op_hit && reset_armed && op == SFM_OP_RESET |=> soft_reset_o ##1 state == SFM_ST_IDLE && !reset_armed)
    else $error("software reset not performed");

  disarm_a: assert property ( // [RULE_14]
    op_hit && op != SFM_OP_RESET_ARM |=> !reset_armed ##1 !soft_reset_o)
    else $error("reset left armed after other command");

  abort_pe_a: assert property ( // [RULE_15]
    soft_reset_o && pe_busy |=> pe_abort_o && !pe_busy)
    else $error("running program or erase not aborted");

endmodule

// File: common/sfm_pkg.sv
// Shared constants and types for the flash mode and reset controller
package sfm_pkg;

  // Opcodes seen by the command decoder
  localparam logic [7:0] SFM_OP_CONT_RELEASE = 8'hFF;
  localparam logic [7:0] SFM_OP_QPI_ENTER = 8'h38;
  localparam logic [7:0] SFM_OP_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] SFM_OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] SFM_OP_RESET_ARM = 8'h66;
  localparam logic [7:0] SFM_OP_RESET = 8'h99;
  localparam logic [7:0] SFM_OP_NOP = 8'h00;

  // Mode byte continue field value and its position
  localparam logic [1:0] SFM_MODE_CONTINUE = 2'h2;
  localparam int SFM_MODE_FIELD_LSB = 4;

  // Address bytes before the mode byte, last index
  localparam logic [1:0] SFM_ADDR_LAST = 2'h2;

  // Parameter table words, bytes 67H:64H and 6BH:68H
  localparam logic [31:0] SFM_PTAB_64 = 32'h6477F99E;
  localparam logic [31:0] SFM_PTAB_68 = 32'hFFFFCBFC;

  // Register byte offsets
  localparam logic [7:0] SFM_OFS_CTRL = 8'h00;
  localparam logic [7:0] SFM_OFS_STATUS = 8'h04;
  localparam logic [7:0] SFM_OFS_PTAB_64 = 8'h08;
  localparam logic [7:0] SFM_OFS_PTAB_68 = 8'h0C;

  // Control register field positions
  localparam int SFM_CTRL_QUAD_ENABLE = 0;
  localparam int SFM_CTRL_WEL = 1;
  localparam int SFM_CTRL_SUSP = 2;
  localparam int SFM_CTRL_WRAP_LSB = 4;
  localparam int SFM_CTRL_PE_BUSY = 8;

  // Reset values
  localparam logic [1:0] SFM_WRAP_RST = 2'h0;
  localparam logic [7:0] SFM_CNT_RST = 8'h00;

  // Bus responses
  localparam logic [1:0] SFM_RESP_OKAY = 2'h0;
  localparam logic [1:0] SFM_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SFM_W_X1 = 2'b00,
    SFM_W_X2 = 2'b01,
    SFM_W_X4 = 2'b11
  } sfm_width_e;

  typedef enum logic [2:0] {
    SFM_ST_IDLE = 3'b000,
    SFM_ST_OPC = 3'b001,
    SFM_ST_ADDR = 3'b011,
    SFM_ST_MODE = 3'b010,
    SFM_ST_DATA = 3'b110
  } sfm_state_e;

endpackage

// File: common/sfm_link_if.sv
// Byte stream between the link receiver and the command decoder
interface sfm_link_if;
  import sfm_pkg::*;
  sfm_width_e width;
  logic byte_valid;
  logic [7:0] byte_data;
  logic frame_start;
  logic frame_end;
  modport rx (input width, output byte_valid, byte_data, frame_start, frame_end);
  modport dec (output width, input byte_valid, byte_data, frame_start, frame_end);
endinterface

// File: verilog/sfm_link_rx.sv
// Serial link receiver: pin synchronisers, clock edge finder, byte framer
module sfm_link_rx
  import sfm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic flash_cs_n_i,
  input wire logic flash_sclk_i,
  input wire logic [3:0] flash_io_i,
  sfm_link_if.rx lk
);

  logic cs_s1, cs_s2, cs_d;
  logic sclk_s1, sclk_s2, sclk_d;
  logic [3:0] io_s1, io_s2;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [3:0] next_cnt;
  logic [7:0] next_shift;

  // Shift in one bus beat; single width reads line 0 only
  function automatic logic [7:0] shift_in(logic [7:0] sh, logic [3:0] io, sfm_width_e w);
    case (w)
      SFM_W_X4: shift_in = {sh[3:0], io};
      SFM_W_X2: shift_in = {sh[5:0], io[1:0]};
      default: shift_in = {sh[6:0], io[0]};
    endcase
  endfunction

  function automatic logic [3:0] beat_bits(sfm_width_e w);
    case (w)
      SFM_W_X4: beat_bits = 4'h4;
      SFM_W_X2: beat_bits = 4'h2;
      default: beat_bits = 4'h1;
    endcase
  endfunction

  // Two stages on every pin; chip select and clock get a third stage for edge finding
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_s1 <= flash_cs_n_i;
      cs_s2 <= cs_s1;
      sclk_s1 <= flash_sclk_i;
      sclk_s2 <= sclk_s1;
      io_s1 <= flash_io_i;
      io_s2 <= io_s1;
      cs_d <= cs_s2;
      sclk_d <= sclk_s2;
    end
  end

  assign next_shift = shift_in(shift, io_s2, lk.width);
  assign next_cnt = bit_cnt + beat_bits(lk.width);

  // Byte framing on rising link clock; deselect drops a partial byte
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      lk.byte_valid <= 1'b0;
      lk.byte_data <= 8'h00;
    end else begin
      lk.byte_valid <= 1'b0;
      if (cs_s2) begin
        bit_cnt <= 4'h0;
      end else if (sclk_s2 && !sclk_d) begin
        shift <= next_shift;
        if (next_cnt >= 4'h8) begin
          bit_cnt <= 4'h0;
          lk.byte_valid <= 1'b1;
          lk.byte_data <= next_shift;
        end else begin
          bit_cnt <= next_cnt;
        end
      end
    end
  end

  // Frame edges from the synchronised chip select
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lk.frame_start <= 1'b0;
      lk.frame_end <= 1'b0;
    end else begin
      lk.frame_start <= cs_d && !cs_s2;
      lk.frame_end <= !cs_d && cs_s2;
    end
  end

endmodule

// File: verification/sfm_host_model.sv
// Host-side flash controller model: chip select, serial clock and data lines
module sfm_host_model (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: deselected, clock parked low between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'h5;
  end

  // One byte MSB first; unused lines carry junk so stray sampling shows up
  task automatic put_byte(input logic [7:0] b, input int w);
    logic [11:0] ext;
    logic [3:0] msk;
    ext = {4'h0, b};
    msk = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
    for (int i = 8 - w; i >= 0; i -= w) begin
      io_o <= (ext[i +: 4] & msk) | (~msk & ~io_o);
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
  endtask

  // Frame: optional opcode, then n_tail bytes taken from the top of tail
  task automatic frame(input bit with_op, input logic [7:0] op, input int ow, input int n_tail,
                       input int tw, input logic [31:0] tail);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    if (with_op) put_byte(op, ow);
    for (int k = 0; k < n_tail; k++) put_byte(tail[31 - 8 * k -: 8], tw);
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // Released lines must not keep the last value
    io_o <= ~io_o;
    repeat (12) @(posedge clk_i);
  endtask
endmodule

// File: verification/sfm_ctrl_top_bench.sv
// Self-checking bench for the flash mode and reset controller
module sfm_ctrl_top_bench
  import sfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cs_n, sclk, cont, qpi, srst, pabort;
  logic [1:0] bresp, rresp;
  logic [3:0] io;
  int n_errors = 0;
  int num_checks = 0;
  int n_srst = 0;
  int n_abort = 0;
  int cycles = 0;

  sfm_host_model u_host (.clk_i(clk_sys), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(io));

  sfm_ctrl_top u_dut (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .flash_cs_n_i(cs_n), .flash_sclk_i(sclk), .flash_io_i(io),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cont_read_o(cont), .qpi_mode_o(qpi), .soft_reset_o(srst), .pe_abort_o(pabort)
  );

  // 25 MHz system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // Pulse counters; counting high cycles also catches pulses longer than one cycle
  always @(posedge clk_sys) begin
    cycles++;
    if (srst === 1'b1) n_srst++;
    if (pabort === 1'b1) n_abort++;
    if (cycles == 40000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] eresp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, eresp}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] eresp, input string what);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp, what);
    chk({30'h0, rresp}, {30'h0, eresp}, what);
  endtask

  // Opcode-only frame at the given line width
  task automatic cmd(input logic [7:0] b, input int w);
    u_host.frame(1'b1, b, w, 0, 1, 32'h0);
  endtask

  // Mode levels, looked at once a register write has had time to land
  task automatic flags(input logic c, input logic q, input string what);
    repeat (2) @(posedge clk_sys);
    chk({30'h0, cont, qpi}, {30'h0, c, q}, what);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    // 0.3 ms at 25 MHz before the first command
    repeat (7500) @(posedge clk_sys);
    cmd(SFM_OP_CONT_RELEASE, 1);
    // Register map, table words, refused accesses
    rd(SFM_OFS_CTRL, 32'h0, SFM_RESP_OKAY, "ctrl reset");
    rd(SFM_OFS_STATUS, 32'h0, SFM_RESP_OKAY, "status reset");
    rd(SFM_OFS_PTAB_64, 32'h6477F99E, SFM_RESP_OKAY, "table 64");
    wr(SFM_OFS_PTAB_68, 32'h0, SFM_RESP_OKAY);
    rd(SFM_OFS_PTAB_68, 32'hFFFFCBFC, SFM_RESP_OKAY, "table 68");
    wr(8'h10, 32'h1, SFM_RESP_SLVERR);
    rd(8'h10, 32'h0, SFM_RESP_SLVERR, "unmapped read");
    rd(SFM_OFS_CTRL, 32'h0, SFM_RESP_OKAY, "ctrl untouched");
    // Low byte strobe only: the busy bit in byte 1 must not be written
    wstrb <= 4'h1;
    wr(SFM_OFS_CTRL, 32'h100, SFM_RESP_OKAY);
    wstrb <= 4'hF;
    rd(SFM_OFS_CTRL, 32'h0, SFM_RESP_OKAY, "byte strobe");
    $display("test registers done");
    // Four-wire mode entry and both exits
    cmd(SFM_OP_QPI_ENTER, 1);
    flags(1'b0, 1'b0, "entry without quad enable");
    wr(SFM_OFS_CTRL, 32'h37, SFM_RESP_OKAY);
    cmd(SFM_OP_QPI_ENTER, 1);
    flags(1'b0, 1'b1, "entry");
    rd(SFM_OFS_CTRL, 32'h37, SFM_RESP_OKAY, "kept on entry");
    cmd(SFM_OP_CONT_RELEASE, 4);
    flags(1'b0, 1'b0, "exit by opcode");
    rd(SFM_OFS_CTRL, 32'h37, SFM_RESP_OKAY, "kept on exit");
    cmd(SFM_OP_QPI_ENTER, 1);
    wr(SFM_OFS_CTRL, 32'h36, SFM_RESP_OKAY);
    flags(1'b0, 1'b0, "exit by quad enable clear");
    wr(SFM_OFS_CTRL, 32'h37, SFM_RESP_OKAY);
    $display("test four-wire done");
    // Continuous read: capture, reserved bits, deselect, leave, release
    u_host.frame(1'b1, 8'h0B, 1, 4, 1, 32'h00001220);
    flags(1'b0, 1'b0, "mode byte of other read");
    u_host.frame(1'b1, SFM_OP_QUAD_IO_READ, 1, 4, 4, 32'h00001220);
    flags(1'b1, 1'b0, "quad continue");
    u_host.frame(1'b0, 8'h00, 1, 4, 4, 32'h661234EF);
    flags(1'b1, 1'b0, "reserved bits set");
    rd(SFM_OFS_STATUS, 32'h1, SFM_RESP_OKAY, "no arm in continuous");
    u_host.frame(1'b0, 8'h00, 1, 4, 4, 32'h12345600);
    flags(1'b0, 1'b0, "quad leave");
    u_host.frame(1'b1, SFM_OP_DUAL_IO_READ, 1, 4, 2, 32'h0012346C);
    flags(1'b1, 1'b0, "dual continue");
    u_host.frame(1'b0, 8'h00, 1, 1, 2, 32'hFF000000);
    flags(1'b0, 1'b0, "release");
    cmd(SFM_OP_QPI_ENTER, 1);
    u_host.frame(1'b1, SFM_OP_QUAD_IO_READ, 4, 4, 4, 32'h00000020);
    flags(1'b1, 1'b1, "continue in four-wire");
    u_host.frame(1'b0, 8'h00, 1, 1, 4, 32'hFF000000);
    flags(1'b0, 1'b0, "release both");
    $display("test continuous done");
    // Software reset: disarm by no-op and by other opcode, then real resets
    wr(SFM_OFS_CTRL, 32'h137, SFM_RESP_OKAY);
    cmd(SFM_OP_RESET_ARM, 1);
    rd(SFM_OFS_STATUS, 32'h4, SFM_RESP_OKAY, "armed");
    cmd(SFM_OP_NOP, 1);
    cmd(SFM_OP_RESET, 1);
    chk(n_srst, 0, "no-op disarms");
    rd(SFM_OFS_CTRL, 32'h137, SFM_RESP_OKAY, "no-op leaves settings");
    cmd(SFM_OP_RESET_ARM, 1);
    cmd(8'h05, 1);
    cmd(SFM_OP_RESET, 1);
    chk(n_srst, 0, "other opcode disarms");
    cmd(SFM_OP_QPI_ENTER, 1);
    cmd(SFM_OP_RESET_ARM, 4);
    cmd(SFM_OP_RESET, 4);
    chk(n_srst, 1, "reset pulse");
    chk(n_abort, 1, "abort while busy");
    flags(1'b0, 1'b0, "reset leaves four-wire");
    rd(SFM_OFS_CTRL, 32'h1, SFM_RESP_OKAY, "volatile cleared");
    rd(SFM_OFS_STATUS, 32'h100, SFM_RESP_OKAY, "reset count");
    cmd(SFM_OP_RESET_ARM, 1);
    cmd(SFM_OP_RESET, 1);
    chk(n_srst, 2, "second reset");
    chk(n_abort, 1, "no abort when idle");
    rd(SFM_OFS_STATUS, 32'h200, SFM_RESP_OKAY, "count after two");
    $display("test reset done");
    finish_test();
  end
endmodule
